/* File: design/ncopf_osc.sv */
// one oscillator: accumulator and phase-shifted lookup address
`timescale 1ns/1ps
module ncopf_osc #(
	parameter int AW = 32,
	parameter int PW = 16
) (
	input  wire logic          clk_i,
	input  wire logic          rstn_i,
	input  wire logic [AW-1:0] freq_i,
	input  wire logic [PW-1:0] phase_i,
	output logic      [AW-1:0] acc_o,
	output logic      [PW-1:0] addr_o
);
	// ==========================================
	// signed word added as unsigned gives the same wrap modulo 2^32
	wire [AW-1:0] acc_nxt = acc_o + freq_i; // R08 R09 R10
	wire [PW-1:0] addr_nxt = acc_o[AW-1 -: PW] + phase_i; // R01 R02

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			acc_o  <= '0;
			addr_o <= '0;
		end else begin
			acc_o  <= acc_nxt;
			addr_o <= addr_nxt;
		end
	end

	acc_step_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$past(rstn_i) |-> acc_o == AW'($past(acc_o) + $past(freq_i)))
		else $error("accumulator step wrong"); // R10
	addr_sum_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$past(rstn_i) |-> addr_o == PW'($past(acc_o[AW-1 -: PW]) + $past(phase_i)))
		else $error("lookup address wrong"); // R01
	acc_untouched_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$changed(phase_i) && $stable(freq_i) |=> acc_o == AW'($past(acc_o) + $past(freq_i)))
		else $error("phase shift disturbed accumulator"); // R02
endmodule // ncopf_osc

/* File: design/ncopf_pkg.sv */
// package: register map, reset values and widths for the oscillator register block
package ncopf_pkg;
	// ==========================================
	// register indices (printed offsets are not multiples of four)
	localparam logic [7:0]  AB_PHASE_OFFSET_IDX   = 8'h12;
	localparam logic [7:0]  CD_PHASE_OFFSET_IDX   = 8'h13;
	localparam logic [7:0]  AB_FREQ_WORD_LOW_IDX  = 8'h14;
	localparam logic [7:0]  AB_FREQ_WORD_HIGH_IDX = 8'h15;
	localparam logic [7:0]  CD_FREQ_WORD_LOW_IDX  = 8'h16;
	localparam logic [7:0]  CD_FREQ_WORD_HIGH_IDX = 8'h17;
	localparam logic [7:0]  AUTO_SYNC_CTRL_IDX    = 8'h1F;
	localparam logic [7:0]  AB_ACC_STATUS_IDX     = 8'h20;
	localparam logic [7:0]  CD_ACC_STATUS_IDX     = 8'h21;
	// ==========================================
	// reset values and field layout
	localparam logic [15:0] REG_RESET       = 16'h0000;
	localparam logic        AUTO_SYNC_RESET = 1'b1;
	localparam int          AUTO_SYNC_AB_BIT = 0;
	localparam int          AUTO_SYNC_CD_BIT = 1;
	localparam int          REG_WIDTH        = 16;
	localparam int          ACC_WIDTH        = 32;
endpackage

/* File: design/ncopf_stage.sv */
// one channel pair: staged settings, active copy loaded on sync
`timescale 1ns/1ps
module ncopf_stage #(
	parameter int W = 16
) (
	input  wire logic           clk_i,
	input  wire logic           rstn_i,
	input  wire logic           wr_phase_i,
	input  wire logic           wr_low_i,
	input  wire logic           wr_high_i,
	input  wire logic [W-1:0]   wdata_i,
	input  wire logic           sync_en_i,
	output logic      [W-1:0]   stg_phase_o,
	output logic      [2*W-1:0] stg_freq_o,
	output logic      [W-1:0]   act_phase_o,
	output logic      [2*W-1:0] act_freq_o
);
	// ==========================================
	// staging and active registers
	logic [W-1:0]   phase_r;
	logic [W-1:0]   low_r;
	logic [W-1:0]   high_r;
	wire            load = wr_phase_i & sync_en_i;
	wire  [2*W-1:0] new_freq = {high_r, low_r};

	// frequency halves only touch staging
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			phase_r <= '0;
			low_r   <= '0;
			high_r  <= '0;
		end else begin
			if (wr_phase_i) phase_r <= wdata_i;
			if (wr_low_i)   low_r   <= wdata_i; // R05
			if (wr_high_i)  high_r  <= wdata_i; // R05
		end
	end

	// all three settings move together; phase taken from the bus write itself
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			act_phase_o <= '0;
			act_freq_o  <= '0;
		end else if (load) begin // R03 R04
			act_phase_o <= wdata_i;
			act_freq_o  <= new_freq;
		end
	end

	assign stg_phase_o = phase_r;
	assign stg_freq_o  = new_freq;

	active_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!load |=> $stable(act_freq_o) && $stable(act_phase_o))
		else $error("active settings moved without a sync"); // R05
	sync_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		load |=> act_freq_o == $past(new_freq) && act_phase_o == $past(wdata_i))
		else $error("sync did not load all settings"); // R03
endmodule // ncopf_stage

/* File: design/ncopf_top.sv */
// top: APB register slave and two fine mixer oscillators
// Operation
// R01: lookup address is phase offset plus top 16 accumulator bits.
// R02: offset applies after accumulation, never altering the accumulated frequency.
// R03: AB phase write with auto-sync loads AB phase and frequency together.
// R04: CD phase write with auto-sync loads CD phase and frequency together.
// R05: frequency word writes update staging only until a sync load.
// R06: host writes AB frequency halves first, AB phase last.
// R07: host writes CD frequency halves first, CD phase last.
// R08: frequency word is signed two's complement, 32 bits.
// R09: one frequency LSB equals sample rate over two to the thirty-two.
// R10: accumulator adds active frequency each clock, wrapping modulo 2^32.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module ncopf_top (
	input  wire logic        CLK_I,
	input  wire logic        RSTN_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic      [15:0] AB_LUT_ADDR_O,
	output logic      [15:0] CD_LUT_ADDR_O
);
	localparam int W = ncopf_pkg::REG_WIDTH;
	// ==========================================
	// APB decode: byte address is four times the register index
	wire        access  = PSEL_I & PENABLE_I;
	wire        aligned = (PADDR_I[1:0] == 2'b00) && (PADDR_I[11:10] == 2'b00);
	wire [7:0]  idx     = PADDR_I[9:2];
	wire        hit_abp = idx == ncopf_pkg::AB_PHASE_OFFSET_IDX;
	wire        hit_cdp = idx == ncopf_pkg::CD_PHASE_OFFSET_IDX;
	wire        hit_abl = idx == ncopf_pkg::AB_FREQ_WORD_LOW_IDX;
	wire        hit_abh = idx == ncopf_pkg::AB_FREQ_WORD_HIGH_IDX;
	wire        hit_cdl = idx == ncopf_pkg::CD_FREQ_WORD_LOW_IDX;
	wire        hit_cdh = idx == ncopf_pkg::CD_FREQ_WORD_HIGH_IDX;
	wire        hit_syn = idx == ncopf_pkg::AUTO_SYNC_CTRL_IDX;
	wire        hit_abs = idx == ncopf_pkg::AB_ACC_STATUS_IDX;
	wire        hit_cds = idx == ncopf_pkg::CD_ACC_STATUS_IDX;
	wire        rw_hit  = hit_abp | hit_cdp | hit_abl | hit_abh | hit_cdl | hit_cdh | hit_syn;
	wire        mapped  = aligned & (rw_hit | hit_abs | hit_cds);
	wire        wr      = access & PWRITE_I & aligned;
	wire        rd_ok   = access & ~PWRITE_I & mapped;
	// status registers are read-only; a write to one is an error
	wire        bad     = access & (~mapped | (PWRITE_I & ~rw_hit));
	wire [15:0] wdata   = PWDATA_I[15:0];

	// ==========================================
	// auto-sync enables, one per channel pair
	logic [1:0] sync_en_r;
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			sync_en_r <= {2{ncopf_pkg::AUTO_SYNC_RESET}};
		end else if (wr & hit_syn) begin
			sync_en_r <= wdata[1:0];
		end
	end

	// ==========================================
	// channel pairs
	logic [W-1:0]   ab_stg_phase;
	logic [2*W-1:0] ab_stg_freq;
	logic [W-1:0]   ab_osc_phase_shift;
	logic [2*W-1:0] ab_osc_freq_word;
	logic [W-1:0]   cd_stg_phase;
	logic [2*W-1:0] cd_stg_freq;
	logic [W-1:0]   cd_osc_phase_shift;
	logic [2*W-1:0] cd_osc_freq_word;
	logic [2*W-1:0] ab_acc;
	logic [2*W-1:0] cd_acc;

	ncopf_stage #(.W(W)) u_ab_stage (
		.clk_i       (CLK_I),
		.rstn_i      (RSTN_I),
		.wr_phase_i  (wr & hit_abp), // R03
		.wr_low_i    (wr & hit_abl),
		.wr_high_i   (wr & hit_abh),
		.wdata_i     (wdata),
		.sync_en_i   (sync_en_r[ncopf_pkg::AUTO_SYNC_AB_BIT]),
		.stg_phase_o (ab_stg_phase),
		.stg_freq_o  (ab_stg_freq),
		.act_phase_o (ab_osc_phase_shift),
		.act_freq_o  (ab_osc_freq_word)
	);

	ncopf_stage #(.W(W)) u_cd_stage (
		.clk_i       (CLK_I),
		.rstn_i      (RSTN_I),
		.wr_phase_i  (wr & hit_cdp), // R04
		.wr_low_i    (wr & hit_cdl),
		.wr_high_i   (wr & hit_cdh),
		.wdata_i     (wdata),
		.sync_en_i   (sync_en_r[ncopf_pkg::AUTO_SYNC_CD_BIT]),
		.stg_phase_o (cd_stg_phase),
		.stg_freq_o  (cd_stg_freq),
		.act_phase_o (cd_osc_phase_shift),
		.act_freq_o  (cd_osc_freq_word)
	);

	ncopf_osc #(.AW(2*W), .PW(W)) u_ab_osc (
		.clk_i   (CLK_I),
		.rstn_i  (RSTN_I),
		.freq_i  (ab_osc_freq_word),
		.phase_i (ab_osc_phase_shift),
		.acc_o   (ab_acc),
		.addr_o  (AB_LUT_ADDR_O)
	);

	ncopf_osc #(.AW(2*W), .PW(W)) u_cd_osc (
		.clk_i   (CLK_I),
		.rstn_i  (RSTN_I),
		.freq_i  (cd_osc_freq_word),
		.phase_i (cd_osc_phase_shift),
		.acc_o   (cd_acc),
		.addr_o  (CD_LUT_ADDR_O)
	);

	// ==========================================
	// read mux: staging values read back, status shows accumulator top bits
	wire [15:0] rd_val =
		hit_abp ? ab_stg_phase :
		hit_cdp ? cd_stg_phase :
		hit_abl ? ab_stg_freq[15:0] :
		hit_abh ? ab_stg_freq[31:16] :
		hit_cdl ? cd_stg_freq[15:0] :
		hit_cdh ? cd_stg_freq[31:16] :
		hit_syn ? {14'h0000, sync_en_r} :
		hit_abs ? ab_acc[31:16] :
		hit_cds ? cd_acc[31:16] : 16'h0000;

	// zero-wait slave; read data registered at the access edge
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			PRDATA_O <= 32'h00000000;
		end else if (rd_ok) begin
			PRDATA_O <= {16'h0000, rd_val};
		end
	end

	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = bad;

	// ==========================================
	// checks
	sequence ab_freq_write_s;
		wr & (hit_abl | hit_abh);
	endsequence
	ab_freq_staged_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		ab_freq_write_s ##0 !(wr & hit_abp) |=> $stable(ab_osc_freq_word))
		else $error("AB frequency write reached the mixer"); // R05
	cd_sync_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		wr & hit_cdp & sync_en_r[1] |=> cd_osc_freq_word == cd_stg_freq
		&& cd_osc_phase_shift == cd_stg_phase)
		else $error("CD sync did not load staged settings"); // R04
	ab_sync_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		wr & hit_abp & sync_en_r[0] |=> ab_osc_freq_word == ab_stg_freq
		&& ab_osc_phase_shift == ab_stg_phase)
		else $error("AB sync did not load staged settings"); // R03
	unmapped_err_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		access & ~aligned |-> PSLVERR_O)
		else $error("unmapped access without error");
endmodule // ncopf_top

/* File: tb/tb_top.sv */
// self-checking bench for the oscillator register block
`timescale 1ns/1ps
module tb_top;
	logic        CLK_I     = 1'b0;
	logic        RSTN_I    = 1'b0;
	logic        PSEL_I    = 1'b0;
	logic        PENABLE_I = 1'b0;
	logic        PWRITE_I  = 1'b0;
	logic [11:0] PADDR_I   = 12'h000;
	logic [31:0] PWDATA_I  = 32'h00000000;
	logic [31:0] PRDATA_O;
	logic        PREADY_O;
	logic        PSLVERR_O;
	logic [15:0] AB_LUT_ADDR_O;
	logic [15:0] CD_LUT_ADDR_O;
	logic [31:0] exp_q[$];
	logic        rd_pend   = 1'b0;
	int          bad_count = 0;
	int          checked   = 0;
	integer      seed      = 32'h86B3E0F8;
	logic [31:0] v[6];

	ncopf_top dut_u (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
		.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
		.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .AB_LUT_ADDR_O(AB_LUT_ADDR_O),
		.CD_LUT_ADDR_O(CD_LUT_ADDR_O));

	always #4 CLK_I = ~CLK_I;

	// ==========================================
	// shared helpers
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, s);
			bad_count++;
		end
	endtask

	// one transfer; the request is left up so back-to-back setups need no idle cycle
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic err);
		PSEL_I    <= 1'b1;
		PENABLE_I <= 1'b0;
		PWRITE_I  <= w;
		PADDR_I   <= {2'h0, idx, 2'h0};
		PWDATA_I  <= d;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		do @(posedge CLK_I); while (PREADY_O !== 1'b1);
		chk("pslverr", {31'h0, err}, {31'h0, PSLVERR_O});
		if (!w) exp_q.push_back(d);
	endtask

	task idle();
		PSEL_I    <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask

	function logic [15:0] lut(input int ch);
		return (ch != 0) ? CD_LUT_ADDR_O : AB_LUT_ADDR_O;
	endfunction

	// per-cycle address step; sampled on the falling edge where outputs are settled
	task delta(input int ch, input logic [15:0] e);
		logic [15:0] p;
		@(negedge CLK_I);
		p = lut(ch);
		repeat (8) begin
			@(negedge CLK_I);
			chk("lut step", {16'h0, e}, {16'h0, lut(ch) - p});
			p = lut(ch);
		end
		@(posedge CLK_I);
	endtask

	// read data is registered at the access edge, so it is compared one edge later
	always @(posedge CLK_I) begin
		if (rd_pend) chk("prdata", exp_q.pop_front(), PRDATA_O);
		rd_pend <= PSEL_I && PENABLE_I && !PWRITE_I && PREADY_O;
	end

	task summarize();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial begin
		repeat (4) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		// reset values, then random staged values read back
		for (int i = 0; i < 6; i++) apb(1'b0, 8'h12 + i[7:0], 32'h0, 1'b0);
		apb(1'b0, 8'h1F, 32'h3, 1'b0);
		// accumulators stay at zero while the reset frequency word is zero
		apb(1'b0, 8'h20, 32'h0, 1'b0);
		apb(1'b0, 8'h21, 32'h0, 1'b0);
		for (int i = 0; i < 6; i++) begin
			v[i] = $random(seed);
			apb(1'b1, 8'h12 + i[7:0], v[i], 1'b0);
		end
		for (int i = 0; i < 6; i++) apb(1'b0, 8'h12 + i[7:0], {16'h0, v[i][15:0]}, 1'b0);
		apb(1'b1, 8'h30, 32'hFFFF, 1'b1);
		apb(1'b1, 8'h20, 32'hFFFF, 1'b1);
		idle();
		// second reset clears accumulators and active settings
		RSTN_I <= 1'b0;
		repeat (2) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		for (int ch = 0; ch < 2; ch++) begin
			apb(1'b1, 8'h12 + ch[7:0], 32'h1234, 1'b0);
			idle();
			repeat (3) @(posedge CLK_I);
			@(negedge CLK_I);
			chk("lut addr", 32'h1234, {16'h0, lut(ch)});
			@(posedge CLK_I);
			apb(1'b1, 8'h14 + {ch[6:0], 1'b0}, 32'h0, 1'b0);
			apb(1'b1, 8'h15 + {ch[6:0], 1'b0}, 32'h1, 1'b0);
			idle();
			delta(ch, 16'h0);
			apb(1'b1, 8'h12 + ch[7:0], 32'h1234, 1'b0);
			idle();
			repeat (2) @(posedge CLK_I);
			delta(ch, 16'h1);
			apb(1'b1, 8'h15 + {ch[6:0], 1'b0}, 32'hFFFF, 1'b0);
			apb(1'b1, 8'h12 + ch[7:0], 32'h4000, 1'b0);
			idle();
			repeat (2) @(posedge CLK_I);
			delta(ch, 16'hFFFF);
		end
		// auto-sync off: a phase write only stages, the running address must not jump
		apb(1'b1, 8'h1F, 32'h0, 1'b0);
		for (int ch = 0; ch < 2; ch++) begin
			apb(1'b1, 8'h12 + ch[7:0], 32'h7777, 1'b0);
			idle();
			delta(ch, 16'hFFFF);
		end
		apb(1'b0, 8'h13, 32'h7777, 1'b0);
		apb(1'b0, 8'h1F, 32'h0, 1'b0);
		idle();
		repeat (3) @(posedge CLK_I);
		summarize();
	end

	// watchdog well beyond the under two hundred cycles the sequence needs
	initial begin
		#100000;
		bad_count++;
		summarize();
	end
endmodule // tb_top
